// file: fbcsw_defines.svh
`ifndef FBCSW_DEFINES_SVH
`define FBCSW_DEFINES_SVH

// Operate mode, state machine and control place selector codes
`define FBCSW_OPMODE_PROFILE 2'h1
`define FBCSW_OPMODE_BYPASS 2'h2
`define FBCSW_SMSEL_BASIC 2'h1
`define FBCSW_SMSEL_PROFILE 2'h2
`define FBCSW_PLACE_REMOTE 2'h3

// Status word source identifier that selects the built-in profile word
`define FBCSW_DEF_STATE_SRC 16'h0041

// Command word bit positions, profile and basic layouts
`define FBCSW_CB_ON 0
`define FBCSW_CB_COAST 1
`define FBCSW_CB_QSTOP 2
`define FBCSW_CB_RUN 3
`define FBCSW_CB_RAMP_OUT 4
`define FBCSW_CB_RAMP_HOLD 5
`define FBCSW_CB_RAMP_IN 6
`define FBCSW_CB_FRESET 7
`define FBCSW_CB_INCH1 8
`define FBCSW_CB_INCH2 9
`define FBCSW_CB_REMOTE_EN 10
`define FBCSW_CB_WDOG 11
`define FBCSW_CB_VIN_LO 11
`define FBCSW_CB_VIN_HI 14

// Three-bit scheme positions
`define FBCSW_TB_RUN 0
`define FBCSW_TB_REV 1
`define FBCSW_TB_FRESET 2

// Used-bit masks per scheme
`define FBCSW_MASK_BASIC 16'h7CFF
`define FBCSW_MASK_PROFILE 16'h0FFF
`define FBCSW_MASK_THREEBIT 16'h0007

// Status word bit positions
`define FBCSW_SB_RDY_ON 0
`define FBCSW_SB_RDY_OP 1
`define FBCSW_SB_RUNNING 2
`define FBCSW_SB_FAULT 3
`define FBCSW_SB_NO_COAST 4
`define FBCSW_SB_NO_QSTOP 5
`define FBCSW_SB_INHIBIT 6
`define FBCSW_SB_WARN 7
`define FBCSW_SB_AT_REF 8
`define FBCSW_SB_REMOTE 9
`define FBCSW_SB_FOUT_MAX 10
`define FBCSW_SB_BASIC_RUN 12
`define FBCSW_SB_BASIC_READY 13
`define FBCSW_SB_WDOG_ECHO 15
`define FBCSW_MASK_OB_STATE 16'h0277

// Reset values
`define FBCSW_WORD_RST 16'h0000

// Timing: watchdog counts in 1 ms ticks of a 4 ns clock
`define FBCSW_TICK_NS 1000000
`define FBCSW_CLK_NS 4

`endif

// file: fbcsw_pkg.sv
`default_nettype none

package fbcsw_pkg;

  // Decoded operate mode / state machine combination
  typedef enum logic [3:0] {
    CMB_BASIC = 4'h1,
    CMB_PROFILE = 4'h2,
    CMB_THREEBIT = 4'h4,
    CMB_BLOCKED = 4'h8
  } fbcsw_combo_t;

  // Drive-side profile state machine
  typedef enum logic [2:0] {
    ST_INHIBIT = 3'h1,
    ST_READY = 3'h2,
    ST_RUN = 3'h4
  } fbcsw_state_t;

endpackage

`default_nettype wire

// file: fbcsw_wdog.sv
`default_nettype none

module fbcsw_wdog #(
  parameter int TICK_CYCLES = 250000
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  input wire logic toggle_in,
  input wire logic [15:0] delay_in,
  input wire logic clear_in,
  output logic fault_out
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0] div_q, div_d;
  logic [15:0] cnt_q, cnt_d;
  logic prev_q, prev_d;
  logic fault_q, fault_d;
  logic tick;

  // Millisecond tick and silence counter; a changed bit restarts the count
  always_comb begin
    tick = 1'b0;
    div_d = div_q + 1'b1;
    if (div_q == TW'(TICK_CYCLES - 1)) begin
      div_d = '0;
      tick = 1'b1;
    end
    prev_d = toggle_in;
    cnt_d = cnt_q;
    fault_d = fault_q;
    if (clear_in) begin
      fault_d = 1'b0;
    end
    if (!en_in || delay_in == 16'h0000) begin
      cnt_d = 16'h0000;
    end else if (toggle_in != prev_q) begin
      cnt_d = 16'h0000;
    end else if (cnt_q >= delay_in) begin
      fault_d = 1'b1; // Set wins over a same-cycle clear
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      div_q <= '0;
      cnt_q <= 16'h0000;
      prev_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      prev_q <= prev_d;
      fault_q <= fault_d;
    end
  end

  assign fault_out = fault_q;

  property p_wd_skip;
    @(posedge clk_in) disable iff (!rstn_in)
    (delay_in == 16'h0000) |=> (cnt_q == 16'h0000);
  endproperty
  a_wd_skip: assert property (p_wd_skip) else $error("watchdog counted with zero delay");

  property p_wd_trip;
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(fault_q) |-> ($past(delay_in) != 16'h0000) && ($past(cnt_q) >= $past(delay_in));
  endproperty
  a_wd_trip: assert property (p_wd_trip) else $error("watchdog fault without timeout");

endmodule // fbcsw_wdog

`default_nettype wire

// file: fbcsw_top.sv
// Overview of operation
// - Profile mode with profile machine ignores commands
// - Bypass plus profile machine uses profile decoding
// - Bypass plus basic machine uses three-bit control
// - Bypass status word chosen by source identifier
// - Basic bit 3 is run command
// - Basic bit 7 rising edge resets faults
// - Basic bit 10 enables, 11-14 virtual inputs
// - Basic status fault, warning, running, ready direct
// - Basic status bit 8 reference equals actual
// - Rising bit 0 leaves inhibit to ready
// - Bit 1 low coasts, bit 2 low quick-stops
// - Profile bit 3 starts and stops drive
// - Bit 4 low forces ramp output zero
// - Bit 5 low holds ramp output
// - Bit 6 low forces ramp input zero
// - Bits 8, 9 run inching speeds
// - Bit 10 active only with remote place
// - Watchdog toggle bit stops means fault
// - Fault acknowledge on rising edge only
// - Zero watchdog delay disables monitoring
// - Ramp zero beats hold beats input zero
// - Inching accepted only with ramp bits zero
`default_nettype none
`include "fbcsw_defines.svh"

module fbcsw_top #(
  parameter int TICK_CYCLES = `FBCSW_TICK_NS / `FBCSW_CLK_NS
) (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic [1:0] OPMODE_SEL_IN,
  input wire logic [1:0] SM_SEL_IN,
  input wire logic [1:0] CTRL_PLACE_SEL_IN,
  input wire logic [15:0] STATE_SRC_SEL_IN,
  input wire logic [15:0] WD_DELAY_MS_IN,
  input wire logic [15:0] CMD_WORD_IN,
  input wire logic CMD_UPDATE_IN,
  input wire logic [15:0] OB_STATE_WORD_IN,
  input wire logic [15:0] SEL_STATE_WORD_IN,
  input wire logic DRV_FAULT_IN,
  input wire logic DRV_WARN_IN,
  input wire logic DRV_RUNNING_IN,
  input wire logic DRV_READY_IN,
  input wire logic DRV_AT_REF_IN,
  input wire logic DRV_FOUT_MAX_IN,
  output logic [15:0] STATE_WORD_OUT,
  output logic RUN_REQ_OUT,
  output logic REVERSE_OUT,
  output logic COAST_STOP_OUT,
  output logic QUICK_STOP_OUT,
  output logic FAULT_RESET_OUT,
  output logic RAMP_OUT_ZERO_OUT,
  output logic RAMP_HOLD_OUT,
  output logic RAMP_IN_ZERO_OUT,
  output logic INCH1_OUT,
  output logic INCH2_OUT,
  output logic REMOTE_CTRL_OUT,
  output logic [3:0] VIRT_INPUT_OUT,
  output logic READY_TO_RUN_OUT,
  output logic WDOG_FAULT_OUT,
  output logic CMD_BLOCKED_OUT
);

  fbcsw_pkg::fbcsw_combo_t combo_q, combo_d;
  fbcsw_pkg::fbcsw_state_t st_q, st_d;
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] rise_q, rise_d;
  logic [15:0] mask;
  logic remote_act, fault_any, wd_en, wd_clear, wd_fault, ramp_free;
  logic [15:0] sw_q, sw_d, prof_sw;
  logic run_q, run_d, rev_q, rev_d, coast_q, coast_d, qstop_q, qstop_d;
  logic fres_q, fres_d, rzo_q, rzo_d, rhold_q, rhold_d, rzi_q, rzi_d;
  logic inch1_q, inch1_d, inch2_q, inch2_d, remote_q, remote_d;
  logic [3:0] vin_q, vin_d;
  logic rdy_q, rdy_d, blk_q, blk_d;

  // Combination decode; unknown selector codes fall into the blocked case
  always_comb begin
    combo_d = fbcsw_pkg::CMB_BLOCKED;
    if (OPMODE_SEL_IN == `FBCSW_OPMODE_PROFILE && SM_SEL_IN == `FBCSW_SMSEL_BASIC) begin
      combo_d = fbcsw_pkg::CMB_BASIC;
    end else if (OPMODE_SEL_IN == `FBCSW_OPMODE_BYPASS) begin
      if (SM_SEL_IN == `FBCSW_SMSEL_PROFILE) begin
        combo_d = fbcsw_pkg::CMB_PROFILE;
      end else if (SM_SEL_IN == `FBCSW_SMSEL_BASIC) begin
        combo_d = fbcsw_pkg::CMB_THREEBIT;
      end
    end
    case (combo_q)
      fbcsw_pkg::CMB_BASIC: mask = `FBCSW_MASK_BASIC;
      fbcsw_pkg::CMB_PROFILE: mask = `FBCSW_MASK_PROFILE;
      fbcsw_pkg::CMB_THREEBIT: mask = `FBCSW_MASK_THREEBIT;
      default: mask = `FBCSW_WORD_RST;
    endcase
  end

  // Whole-word sampling with edge capture; a mode change flushes the word
  always_comb begin
    cmd_d = cmd_q;
    rise_d = `FBCSW_WORD_RST;
    if (combo_d != combo_q) begin
      cmd_d = `FBCSW_WORD_RST;
    end else if (CMD_UPDATE_IN && combo_q != fbcsw_pkg::CMB_BLOCKED) begin
      cmd_d = CMD_WORD_IN & mask;
      rise_d = cmd_d & ~cmd_q;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      combo_q <= fbcsw_pkg::CMB_BLOCKED;
      cmd_q <= `FBCSW_WORD_RST;
      rise_q <= `FBCSW_WORD_RST;
    end else begin
      combo_q <= combo_d;
      cmd_q <= cmd_d;
      rise_q <= rise_d;
    end
  end

  // Remote control grant per combination
  always_comb begin
    case (combo_q)
      fbcsw_pkg::CMB_BASIC: remote_act = cmd_q[`FBCSW_CB_REMOTE_EN];
      fbcsw_pkg::CMB_PROFILE: remote_act = cmd_q[`FBCSW_CB_REMOTE_EN] &&
                                           CTRL_PLACE_SEL_IN == `FBCSW_PLACE_REMOTE;
      fbcsw_pkg::CMB_THREEBIT: remote_act = CTRL_PLACE_SEL_IN == `FBCSW_PLACE_REMOTE;
      default: remote_act = 1'b0;
    endcase
    fault_any = DRV_FAULT_IN || wd_fault;
    ramp_free = !(cmd_q[`FBCSW_CB_RAMP_OUT] || cmd_q[`FBCSW_CB_RAMP_HOLD] ||
                  cmd_q[`FBCSW_CB_RAMP_IN]);
    wd_en = combo_q == fbcsw_pkg::CMB_PROFILE && remote_act;
    wd_clear = combo_q == fbcsw_pkg::CMB_PROFILE && rise_q[`FBCSW_CB_FRESET];
  end

  // Profile state machine; stops and faults always fall back to inhibit
  always_comb begin
    st_d = st_q;
    if (combo_q != fbcsw_pkg::CMB_PROFILE) begin
      st_d = fbcsw_pkg::ST_INHIBIT;
    end else if (!cmd_q[`FBCSW_CB_COAST] || !cmd_q[`FBCSW_CB_QSTOP] ||
                 fault_any || !remote_act) begin
      st_d = fbcsw_pkg::ST_INHIBIT;
    end else begin
      case (st_q)
        fbcsw_pkg::ST_INHIBIT: begin
          if (rise_q[`FBCSW_CB_ON]) begin
            st_d = fbcsw_pkg::ST_READY;
          end
        end
        fbcsw_pkg::ST_READY: begin
          if (cmd_q[`FBCSW_CB_ON] && cmd_q[`FBCSW_CB_RUN]) begin
            st_d = fbcsw_pkg::ST_RUN;
          end
        end
        fbcsw_pkg::ST_RUN: begin
          if (!cmd_q[`FBCSW_CB_ON] || !cmd_q[`FBCSW_CB_RUN]) begin
            st_d = fbcsw_pkg::ST_READY;
          end
        end
        default: st_d = fbcsw_pkg::ST_INHIBIT;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      st_q <= fbcsw_pkg::ST_INHIBIT;
    end else begin
      st_q <= st_d;
    end
  end

  // Command outputs; all but the blocked flag idle low outside a usable combination
  always_comb begin
    run_d = 1'b0;
    rev_d = 1'b0;
    coast_d = 1'b0;
    qstop_d = 1'b0;
    fres_d = 1'b0;
    rzo_d = 1'b0;
    rhold_d = 1'b0;
    rzi_d = 1'b0;
    inch1_d = 1'b0;
    inch2_d = 1'b0;
    vin_d = 4'h0;
    blk_d = 1'b0;
    remote_d = remote_act;
    rdy_d = st_q != fbcsw_pkg::ST_INHIBIT;
    case (combo_q)
      fbcsw_pkg::CMB_BASIC: begin
        run_d = cmd_q[`FBCSW_CB_RUN] && remote_act;
        fres_d = rise_q[`FBCSW_CB_FRESET];
        vin_d = cmd_q[`FBCSW_CB_VIN_HI:`FBCSW_CB_VIN_LO];
      end
      fbcsw_pkg::CMB_PROFILE: begin
        run_d = st_q == fbcsw_pkg::ST_RUN;
        coast_d = !cmd_q[`FBCSW_CB_COAST];
        qstop_d = !cmd_q[`FBCSW_CB_QSTOP];
        fres_d = rise_q[`FBCSW_CB_FRESET];
        rzo_d = !cmd_q[`FBCSW_CB_RAMP_OUT];
        rhold_d = cmd_q[`FBCSW_CB_RAMP_OUT] && !cmd_q[`FBCSW_CB_RAMP_HOLD];
        rzi_d = cmd_q[`FBCSW_CB_RAMP_OUT] && cmd_q[`FBCSW_CB_RAMP_HOLD] &&
                !cmd_q[`FBCSW_CB_RAMP_IN];
        inch1_d = cmd_q[`FBCSW_CB_INCH1] && ramp_free && remote_act;
        inch2_d = cmd_q[`FBCSW_CB_INCH2] && ramp_free && remote_act;
      end
      fbcsw_pkg::CMB_THREEBIT: begin
        run_d = cmd_q[`FBCSW_TB_RUN] && remote_act;
        rev_d = cmd_q[`FBCSW_TB_REV];
        fres_d = rise_q[`FBCSW_TB_FRESET];
      end
      default: begin
        blk_d = 1'b1;
        remote_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      run_q <= 1'b0;
      rev_q <= 1'b0;
      coast_q <= 1'b0;
      qstop_q <= 1'b0;
      fres_q <= 1'b0;
      rzo_q <= 1'b0;
      rhold_q <= 1'b0;
      rzi_q <= 1'b0;
      inch1_q <= 1'b0;
      inch2_q <= 1'b0;
      vin_q <= 4'h0;
      remote_q <= 1'b0;
      rdy_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      run_q <= run_d;
      rev_q <= rev_d;
      coast_q <= coast_d;
      qstop_q <= qstop_d;
      fres_q <= fres_d;
      rzo_q <= rzo_d;
      rhold_q <= rhold_d;
      rzi_q <= rzi_d;
      inch1_q <= inch1_d;
      inch2_q <= inch2_d;
      vin_q <= vin_d;
      remote_q <= remote_d;
      rdy_q <= rdy_d;
      blk_q <= blk_d;
    end
  end

  // Returned status word; the blocked case returns all zero
  always_comb begin
    prof_sw = `FBCSW_WORD_RST;
    prof_sw[`FBCSW_SB_RDY_ON] = st_q != fbcsw_pkg::ST_INHIBIT;
    prof_sw[`FBCSW_SB_RDY_OP] = st_q == fbcsw_pkg::ST_RUN;
    prof_sw[`FBCSW_SB_RUNNING] = DRV_RUNNING_IN;
    prof_sw[`FBCSW_SB_FAULT] = fault_any;
    prof_sw[`FBCSW_SB_NO_COAST] = cmd_q[`FBCSW_CB_COAST];
    prof_sw[`FBCSW_SB_NO_QSTOP] = cmd_q[`FBCSW_CB_QSTOP];
    prof_sw[`FBCSW_SB_INHIBIT] = st_q == fbcsw_pkg::ST_INHIBIT;
    prof_sw[`FBCSW_SB_WARN] = DRV_WARN_IN;
    prof_sw[`FBCSW_SB_AT_REF] = DRV_AT_REF_IN;
    prof_sw[`FBCSW_SB_REMOTE] = remote_act;
    prof_sw[`FBCSW_SB_FOUT_MAX] = DRV_FOUT_MAX_IN;
    prof_sw[`FBCSW_SB_WDOG_ECHO] = cmd_q[`FBCSW_CB_WDOG];
    sw_d = `FBCSW_WORD_RST;
    case (combo_q)
      fbcsw_pkg::CMB_BASIC: begin
        sw_d = OB_STATE_WORD_IN & `FBCSW_MASK_OB_STATE;
        sw_d[`FBCSW_SB_FAULT] = DRV_FAULT_IN;
        sw_d[`FBCSW_SB_WARN] = DRV_WARN_IN;
        sw_d[`FBCSW_SB_AT_REF] = DRV_AT_REF_IN;
        sw_d[`FBCSW_SB_BASIC_RUN] = DRV_RUNNING_IN;
        sw_d[`FBCSW_SB_BASIC_READY] = DRV_READY_IN;
      end
      fbcsw_pkg::CMB_PROFILE, fbcsw_pkg::CMB_THREEBIT: begin
        sw_d = (STATE_SRC_SEL_IN == `FBCSW_DEF_STATE_SRC) ? prof_sw
                                                          : SEL_STATE_WORD_IN;
      end
      default: sw_d = `FBCSW_WORD_RST;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      sw_q <= `FBCSW_WORD_RST;
    end else begin
      sw_q <= sw_d;
    end
  end

  // Toggle supervision lives in its own counter block
  fbcsw_wdog #(.TICK_CYCLES(TICK_CYCLES)) u_wdog (
    .clk_in(CLK_SYS_IN),
    .rstn_in(RSTN_IN),
    .en_in(wd_en),
    .toggle_in(cmd_q[`FBCSW_CB_WDOG]),
    .delay_in(WD_DELAY_MS_IN),
    .clear_in(wd_clear),
    .fault_out(wd_fault)
  );

  assign STATE_WORD_OUT = sw_q;
  assign RUN_REQ_OUT = run_q;
  assign REVERSE_OUT = rev_q;
  assign COAST_STOP_OUT = coast_q;
  assign QUICK_STOP_OUT = qstop_q;
  assign FAULT_RESET_OUT = fres_q;
  assign RAMP_OUT_ZERO_OUT = rzo_q;
  assign RAMP_HOLD_OUT = rhold_q;
  assign RAMP_IN_ZERO_OUT = rzi_q;
  assign INCH1_OUT = inch1_q;
  assign INCH2_OUT = inch2_q;
  assign REMOTE_CTRL_OUT = remote_q;
  assign VIRT_INPUT_OUT = vin_q;
  assign READY_TO_RUN_OUT = rdy_q;
  assign WDOG_FAULT_OUT = wd_fault;
  assign CMD_BLOCKED_OUT = blk_q;

  property p_blocked;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (combo_q == fbcsw_pkg::CMB_BLOCKED) |=> CMD_BLOCKED_OUT && !RUN_REQ_OUT;
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked mode still commands");

  property p_sample;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (CMD_UPDATE_IN && combo_q == fbcsw_pkg::CMB_PROFILE && combo_d == combo_q)
      |=> cmd_q == ($past(CMD_WORD_IN) & `FBCSW_MASK_PROFILE);
  endproperty
  a_sample: assert property (p_sample) else $error("word not sampled whole");

  property p_fres_edge;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    FAULT_RESET_OUT |-> $past(rise_q) != `FBCSW_WORD_RST ##1 !FAULT_RESET_OUT;
  endproperty
  a_fres_edge: assert property (p_fres_edge) else $error("fault reset not edge");

  property p_ramp_prio;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (combo_q == fbcsw_pkg::CMB_PROFILE && !cmd_q[`FBCSW_CB_RAMP_OUT])
      |=> RAMP_OUT_ZERO_OUT && !RAMP_HOLD_OUT && !RAMP_IN_ZERO_OUT;
  endproperty
  a_ramp_prio: assert property (p_ramp_prio) else $error("ramp priority broken");

  property p_inch_gate;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (INCH1_OUT || INCH2_OUT) |-> $past(cmd_q[6:4]) == 3'h0;
  endproperty
  a_inch_gate: assert property (p_inch_gate) else $error("inching with ramp bits set");

  property p_inhibit_exit;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (st_q == fbcsw_pkg::ST_INHIBIT && st_d == fbcsw_pkg::ST_READY) |-> rise_q[`FBCSW_CB_ON];
  endproperty
  a_inhibit_exit: assert property (p_inhibit_exit) else $error("inhibit left without edge");

  property p_coast;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (combo_q == fbcsw_pkg::CMB_PROFILE && !cmd_q[`FBCSW_CB_COAST])
      |=> COAST_STOP_OUT && st_q == fbcsw_pkg::ST_INHIBIT;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop not applied");

  property p_remote;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (REMOTE_CTRL_OUT && $past(combo_q) == fbcsw_pkg::CMB_PROFILE)
      |-> $past(CTRL_PLACE_SEL_IN) == `FBCSW_PLACE_REMOTE;
  endproperty
  a_remote: assert property (p_remote) else $error("remote active at wrong place");

  property p_state_src;
    @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (combo_q == fbcsw_pkg::CMB_PROFILE && STATE_SRC_SEL_IN != `FBCSW_DEF_STATE_SRC)
      |=> STATE_WORD_OUT == $past(SEL_STATE_WORD_IN);
  endproperty
  a_state_src: assert property (p_state_src) else $error("status source ignored");

endmodule // fbcsw_top

`default_nettype wire

// file: fbcsw_master.sv
`default_nettype none

module fbcsw_master (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [15:0] word_in,
  input wire logic wd_run_in,
  output logic [15:0] cmd_word_out,
  output logic cmd_update_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] held_q;
  logic [1:0] cnt_q;

  // Idle master at time zero
  initial begin
    held_q = 16'h0000;
    cnt_q = 2'h0;
    cmd_word_out = 16'hFFFF;
    cmd_update_out = 1'b0;
  end

  // Drives on the falling edge; the word is valid only with update high
  always @(negedge clk_in) begin
    cnt_q <= cnt_q + 2'h1;
    if (go_in) begin
      held_q <= word_in;
      cmd_word_out <= word_in;
      cmd_update_out <= 1'b1;
    end else if (wd_run_in && cnt_q == 2'h3) begin
      held_q <= held_q ^ 16'h0800;
      cmd_word_out <= held_q ^ 16'h0800;
      cmd_update_out <= 1'b1;
    end else begin
      // Garbage between updates, so a stale word is never mistaken for data
      cmd_word_out <= ~cmd_word_out;
      cmd_update_out <= 1'b0;
    end
  end
endmodule // fbcsw_master

`default_nettype wire

// file: fieldbus_control_status_word_bench.sv
`default_nettype none

module fieldbus_control_status_word_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, go, wd_run, upd, d_flt, d_wrn, d_run, d_rdy, d_ref, d_fmx;
  logic [1:0] opm, sms, plc;
  logic [15:0] src, wdd, obw, selw, word, cmdw, stw;
  logic run_req, rev, coast, qstop, frst, r_out0, r_hold, r_in0, inch1, inch2;
  logic remote, rtr, wdf, blk;
  logic [3:0] vin;
  logic [2:0] r;
  int bad_count, total_checks, n;

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  fbcsw_master u_master (.clk_in(clk), .go_in(go), .word_in(word), .wd_run_in(wd_run),
    .cmd_word_out(cmdw), .cmd_update_out(upd));

  // Short tick keeps watchdog waits in tens of cycles
  fbcsw_top #(.TICK_CYCLES(4)) dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
    .OPMODE_SEL_IN(opm), .SM_SEL_IN(sms), .CTRL_PLACE_SEL_IN(plc),
    .STATE_SRC_SEL_IN(src), .WD_DELAY_MS_IN(wdd), .CMD_WORD_IN(cmdw),
    .CMD_UPDATE_IN(upd), .OB_STATE_WORD_IN(obw), .SEL_STATE_WORD_IN(selw),
    .DRV_FAULT_IN(d_flt), .DRV_WARN_IN(d_wrn), .DRV_RUNNING_IN(d_run),
    .DRV_READY_IN(d_rdy), .DRV_AT_REF_IN(d_ref), .DRV_FOUT_MAX_IN(d_fmx),
    .STATE_WORD_OUT(stw), .RUN_REQ_OUT(run_req), .REVERSE_OUT(rev),
    .COAST_STOP_OUT(coast), .QUICK_STOP_OUT(qstop), .FAULT_RESET_OUT(frst),
    .RAMP_OUT_ZERO_OUT(r_out0), .RAMP_HOLD_OUT(r_hold), .RAMP_IN_ZERO_OUT(r_in0),
    .INCH1_OUT(inch1), .INCH2_OUT(inch2), .REMOTE_CTRL_OUT(remote),
    .VIRT_INPUT_OUT(vin), .READY_TO_RUN_OUT(rtr), .WDOG_FAULT_OUT(wdf),
    .CMD_BLOCKED_OUT(blk));

  // Comparison helpers
  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  // One update through the master; go is sampled by it on the falling edge
  task automatic post(input logic [15:0] w);
    @(posedge clk);
    go <= 1'b1;
    word <= w;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // Update, then let the two-cycle answer and the state step land
  task automatic send(input logic [15:0] w);
    post(w);
    wt(5);
  endtask

  // Count the one-cycle fault reset pulse
  task automatic pulses(output int cnt);
    cnt = 0;
    repeat (8) begin
      @(negedge clk);
      if (frst === 1'b1) cnt++;
    end
  endtask

  task automatic sel(input logic [1:0] o, input logic [1:0] s, input logic [1:0] p);
    opm = o;
    sms = s;
    plc = p;
    wt(3);
  endtask

  task automatic t_blocked;
    sel(2'h1, 2'h2, 2'h3);
    send(16'h047F);
    chk1(blk, 1'b1, "blocked flag");
    chk1(run_req, 1'b0, "run while blocked");
    chk16(stw, 16'h0000, "status while blocked");
    $display("test blocked done");
  endtask

  task automatic t_basic;
    sel(2'h1, 2'h1, 2'h0);
    obw = 16'hFFFF;
    {d_flt, d_wrn, d_run, d_rdy, d_ref, d_fmx} = 6'h3F;
    send(16'h2C7F);
    chk1(run_req, 1'b1, "basic run");
    chk1(remote, 1'b1, "basic enable");
    chk16({12'h000, vin}, 16'h0005, "virtual inputs");
    chk16(stw, 16'h33FF, "basic status");
    d_ref = 1'b0;
    wt(3);
    chk16(stw, 16'h32FF, "speed not at ref");
    post(16'h2CFF);
    pulses(n);
    chk16(16'(n), 16'h0001, "reset on rise");
    post(16'h2CFF);
    pulses(n);
    chk16(16'(n), 16'h0000, "no reset on level");
    send(16'h2877);
    chk1(run_req, 1'b0, "basic stop");
    chk1(remote, 1'b0, "basic disable");
    d_flt = 1'b0;
    $display("test basic done");
  endtask

  task automatic t_profile;
    sel(2'h2, 2'h2, 2'h3);
    send(16'h0406);
    chk1(rtr, 1'b0, "inhibit before on");
    send(16'h0407);
    chk1(rtr, 1'b1, "ready after on rise");
    send(16'h047F);
    chk1(run_req, 1'b1, "profile start");
    chk16(stw, 16'h06B7, "profile status");
    send(16'h047D);
    chk1(coast, 1'b1, "coast stop");
    chk1(rtr, 1'b0, "coast to inhibit");
    send(16'h047F);
    chk1(rtr, 1'b0, "no restart without on rise");
    send(16'h047E);
    send(16'h047F);
    chk1(run_req, 1'b1, "restart after on rise");
    send(16'h047B);
    chk1(qstop, 1'b1, "quick stop");
    // Every ramp bit combination, priority included
    for (int i = 0; i < 8; i++) begin
      r = 3'(i);
      send(16'h0407 | {9'h000, r, 4'h0});
      chk1(r_out0, ~r[0], "ramp out zero");
      chk1(r_hold, r[0] & ~r[1], "ramp hold");
      chk1(r_in0, r[0] & r[1] & ~r[2], "ramp in zero");
    end
    send(16'h0507);
    chk1(inch1, 1'b1, "inching one");
    send(16'h0617);
    chk1(inch2, 1'b0, "inching refused");
    send(16'h0607);
    chk1(inch2, 1'b1, "inching two");
    sel(2'h2, 2'h2, 2'h0);
    send(16'h047F);
    chk1(remote, 1'b0, "place not remote");
    $display("test profile done");
  endtask

  task automatic t_three;
    sel(2'h2, 2'h1, 2'h3);
    send(16'h7FFB);
    chk1(run_req, 1'b1, "three-bit run");
    chk1(rev, 1'b1, "three-bit reverse");
    chk16({12'h000, vin}, 16'h0000, "upper bits dropped");
    post(16'h7FFF);
    pulses(n);
    chk16(16'(n), 16'h0001, "three-bit reset");
    src = 16'h0010;
    selw = 16'hA5C3;
    wt(3);
    chk16(stw, 16'hA5C3, "selected status");
    src = 16'h0041;
    $display("test three-bit done");
  endtask

  task automatic t_wdog;
    // Three ticks of silence: a toggle slot taken by an update cannot trip it
    wdd = 16'h0003;
    sel(2'h2, 2'h2, 2'h3);
    send(16'h0406);
    send(16'h0407);
    wt(60);
    chk1(wdf, 1'b1, "watchdog trips");
    chk1(rtr, 1'b0, "trip inhibits");
    // Toggling first, since a reset during silence loses to the set
    wd_run <= 1'b1;
    wt(20);
    chk1(wdf, 1'b1, "fault held until reset");
    post(16'h0487);
    wt(60);
    chk1(wdf, 1'b0, "cleared and toggling");
    wd_run <= 1'b0;
    wdd = 16'h0000;
    wt(60);
    chk1(wdf, 1'b0, "zero delay off");
    $display("test watchdog done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence, reset held four cycles
  initial begin
    {rstn, go, wd_run, d_flt, d_wrn, d_run, d_rdy, d_ref, d_fmx} = 9'h000;
    {opm, sms, plc} = 6'h00;
    {wdd, obw, selw, word} = 64'h0;
    src = 16'h0041;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    wt(2);
    t_blocked();
    t_basic();
    t_profile();
    t_three();
    t_wdog();
    give_verdict();
  end

  // Hang guard, some forty-five times the expected run of about 440 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[FAIL] t=%0t run did not finish", $time);
    give_verdict();
  end
endmodule // fieldbus_control_status_word_bench

`default_nettype wire
